// File: shared/flash_host_pkg.sv
// Constants and state type for the host side of the asynchronous flash bus
package flash_host_pkg;
    localparam int CLK_MHZ = 50;
    localparam int ADDR_W = 18;
    localparam int DATA_W = 16;
    localparam int SYNC_STAGES = 3;
    // Bus timing figures in ns; cycle counts round least times up
    localparam int T_RESET_LOW_NS = 500;
    localparam int T_RESET_RECOVER_NS = 100;
    localparam int T_SETUP_NS = 20;
    localparam int T_ACCESS_NS = 100;
    localparam int T_WRITE_PULSE_NS = 60;
    localparam int T_HOLD_NS = 20;
    localparam int T_STANDBY_IDLE_NS = 150;
    localparam int RESET_LOW_CYC = (T_RESET_LOW_NS * CLK_MHZ + 999) / 1000;
    localparam int RESET_RECOVER_CYC = (T_RESET_RECOVER_NS * CLK_MHZ + 999) / 1000;
    localparam int SETUP_CYC = (T_SETUP_NS * CLK_MHZ + 999) / 1000;
    // Three extra cycles cover the pin synchroniser latency
    localparam int ACCESS_CYC = (T_ACCESS_NS * CLK_MHZ + 999) / 1000 + 3;
    localparam int WRITE_PULSE_CYC = (T_WRITE_PULSE_NS * CLK_MHZ + 999) / 1000;
    localparam int HOLD_CYC = (T_HOLD_NS * CLK_MHZ + 999) / 1000;
    localparam int STANDBY_IDLE_CYC = (T_STANDBY_IDLE_NS * CLK_MHZ + 999) / 1000;
    localparam int CNT_W = 8;
    localparam logic [15:0] RESET_DATA = 16'h0000;

    typedef enum logic [3:0] {
        BUS_RESET_LOW,
        BUS_RESET_WAIT,
        BUS_IDLE,
        BUS_READ_SETUP,
        BUS_READ_ACCESS,
        BUS_READ_DONE,
        BUS_WRITE_SETUP,
        BUS_WRITE_PULSE,
        BUS_WRITE_HOLD
    } bus_state_t;
endpackage : flash_host_pkg

// File: shared/pin_sync_if.sv
// Carrier between a pin synchroniser and its user
`timescale 1ns/100ps
interface pin_sync_if #(parameter int WIDTH = 1);
    logic [WIDTH-1:0] raw;
    logic [WIDTH-1:0] clean;
    modport sync (input raw, output clean);
    modport user (output raw, input clean);
endinterface : pin_sync_if

// File: logic/pin_sync.sv
// Three-stage synchroniser; output follows once stages two and three agree
`timescale 1ns/100ps
module pin_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input wire logic clk,
    input wire logic resetn,
    pin_sync_if.sync port
);
    logic [WIDTH-1:0] s1_reg, s2_reg, s3_reg, out_reg;
    logic [WIDTH-1:0] out_next;

    always_comb begin
        out_next = out_reg;
        for (int i = 0; i < WIDTH; i++) begin
            if (s2_reg[i] == s3_reg[i]) begin
                out_next[i] = s3_reg[i];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            s1_reg <= INIT;
            s2_reg <= INIT;
            s3_reg <= INIT;
            out_reg <= INIT;
        end else begin
            s1_reg <= port.raw;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            out_reg <= out_next;
        end
    end

    assign port.clean = out_reg;
endmodule : pin_sync

// File: logic/flash_host.sv
// Host controller that runs read, write, reset and signature cycles on the flash pins
`timescale 1ns/100ps
module flash_host (
    input wire logic clk,
    input wire logic resetn,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire logic cmd_write,
    input wire logic [17:0] cmd_addr,
    input wire logic cmd_byte_hi,
    input wire logic [15:0] cmd_wdata,
    input wire logic cmd_signature,
    input wire logic byte_mode,
    input wire logic reset_request,
    output logic rsp_valid,
    output logic [15:0] rsp_data,
    output logic device_busy,
    output logic chip_enable_n,
    output logic output_drive_n,
    output logic write_strobe_n,
    output logic [17:0] addr_out,
    output logic [15:0] dq_out,
    output logic [15:0] dq_oe,
    input wire logic [15:0] dq_in,
    output logic word_mode,
    output logic reset_unprotect_out,
    output logic reset_unprotect_oe,
    output logic signature_hv,
    input wire logic ready_busy_in
);
    pin_sync_if #(.WIDTH(1)) busy_line_if ();
    pin_sync_if #(.WIDTH(16)) dq_if ();

    assign busy_line_if.raw = ready_busy_in;
    assign dq_if.raw = dq_in;

    // Pull-up makes an undriven line read high, so high is the idle value
    pin_sync #(.WIDTH(1), .INIT(1'b1)) busy_line_sync (.clk(clk), .resetn(resetn), .port(busy_line_if));
    pin_sync #(.WIDTH(16), .INIT(16'h0000)) dq_sync (.clk(clk), .resetn(resetn), .port(dq_if));

    logic line_ready;
    assign line_ready = busy_line_if.clean;

    flash_host_pkg::bus_state_t state_reg, state_next;
    logic [flash_host_pkg::CNT_W-1:0] cnt_reg, cnt_next;
    logic ce_reg, ce_next, oe_reg, oe_next, we_reg, we_next;
    logic [17:0] addr_reg, addr_next;
    logic [15:0] dqo_reg, dqo_next, dqe_reg, dqe_next;
    logic word_reg, word_next, rst_reg, rst_next, hv_reg, hv_next;
    logic ready_reg, ready_next, rsp_reg, rsp_next, busy_reg, busy_next;
    logic [15:0] rdata_reg, rdata_next;

    localparam logic [7:0] RESET_LOW_C = 8'(flash_host_pkg::RESET_LOW_CYC);
    localparam logic [7:0] RECOVER_C = 8'(flash_host_pkg::RESET_RECOVER_CYC);
    localparam logic [7:0] SETUP_C = 8'(flash_host_pkg::SETUP_CYC);
    localparam logic [7:0] ACCESS_C = 8'(flash_host_pkg::ACCESS_CYC);
    localparam logic [7:0] PULSE_C = 8'(flash_host_pkg::WRITE_PULSE_CYC);
    localparam logic [7:0] HOLD_C = 8'(flash_host_pkg::HOLD_CYC);

    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        ce_next = ce_reg;
        oe_next = oe_reg;
        we_next = we_reg;
        addr_next = addr_reg;
        dqo_next = dqo_reg;
        dqe_next = dqe_reg;
        word_next = word_reg;
        rst_next = rst_reg;
        hv_next = hv_reg;
        ready_next = 1'b0;
        rsp_next = 1'b0;
        rdata_next = rdata_reg;
        busy_next = !line_ready;
        if (cnt_reg != 8'h00) begin
            cnt_next = cnt_reg - 8'h01;
        end
        case (state_reg)
            flash_host_pkg::BUS_RESET_LOW: begin
                rst_next = 1'b0;
                if (cnt_reg == 8'h00) begin
                    // Release only after the full low time has elapsed
                    rst_next = 1'b1;
                    cnt_next = RECOVER_C;
                    state_next = flash_host_pkg::BUS_RESET_WAIT;
                end
            end
            flash_host_pkg::BUS_RESET_WAIT: begin
                // Flash may be slow to pull the line low, so the recovery count runs first
                if (cnt_reg == 8'h00 && line_ready) begin
                    state_next = flash_host_pkg::BUS_IDLE;
                    ready_next = 1'b1;
                end
            end
            flash_host_pkg::BUS_IDLE: begin
                ready_next = !reset_request;
                if (reset_request) begin
                    rst_next = 1'b0;
                    cnt_next = RESET_LOW_C;
                    state_next = flash_host_pkg::BUS_RESET_LOW;
                end else if (cmd_valid && cmd_ready) begin
                    ready_next = 1'b0;
                    addr_next = cmd_addr;
                    word_next = !byte_mode;
                    hv_next = cmd_signature && !cmd_write;
                    if (byte_mode) begin
                        // Top data pin carries the byte select as an address bit
                        dqo_next = {cmd_byte_hi, 7'h00, cmd_wdata[7:0]};
                    end else begin
                        dqo_next = cmd_wdata;
                    end
                    dqe_next = byte_mode ? 16'h8000 : 16'h0000;
                    ce_next = 1'b0;
                    cnt_next = SETUP_C;
                    state_next = cmd_write ? flash_host_pkg::BUS_WRITE_SETUP : flash_host_pkg::BUS_READ_SETUP;
                end
            end
            flash_host_pkg::BUS_READ_SETUP: begin
                if (cnt_reg == 8'h00) begin
                    oe_next = 1'b0;
                    cnt_next = ACCESS_C;
                    state_next = flash_host_pkg::BUS_READ_ACCESS;
                end
            end
            flash_host_pkg::BUS_READ_ACCESS: begin
                if (cnt_reg == 8'h00) begin
                    rdata_next = word_reg ? dq_if.clean : {8'h00, dq_if.clean[7:0]};
                    rsp_next = 1'b1;
                    oe_next = 1'b1;
                    ce_next = 1'b1;
                    cnt_next = HOLD_C;
                    state_next = flash_host_pkg::BUS_READ_DONE;
                end
            end
            flash_host_pkg::BUS_READ_DONE: begin
                if (cnt_reg == 8'h00) begin
                    hv_next = 1'b0;
                    dqe_next = 16'h0000;
                    ready_next = 1'b1;
                    state_next = flash_host_pkg::BUS_IDLE;
                end
            end
            flash_host_pkg::BUS_WRITE_SETUP: begin
                // Chip select is already low, so the strobe edge is the later one
                if (cnt_reg == 8'h00) begin
                    we_next = 1'b0;
                    dqe_next = word_reg ? 16'hFFFF : 16'h80FF;
                    cnt_next = PULSE_C;
                    state_next = flash_host_pkg::BUS_WRITE_PULSE;
                end
            end
            flash_host_pkg::BUS_WRITE_PULSE: begin
                // Pulses are whole clock periods, far above the glitch filter
                if (cnt_reg == 8'h00) begin
                    we_next = 1'b1;
                    cnt_next = HOLD_C;
                    state_next = flash_host_pkg::BUS_WRITE_HOLD;
                end
            end
            flash_host_pkg::BUS_WRITE_HOLD: begin
                // Output drive was never lowered on the write path
                if (cnt_reg == 8'h00) begin
                    ce_next = 1'b1;
                    dqe_next = 16'h0000;
                    ready_next = 1'b1;
                    state_next = flash_host_pkg::BUS_IDLE;
                end
            end
            default: begin
                state_next = flash_host_pkg::BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_reg <= flash_host_pkg::BUS_RESET_LOW;
            cnt_reg <= RESET_LOW_C;
            ce_reg <= 1'b1;
            oe_reg <= 1'b1;
            we_reg <= 1'b1;
            addr_reg <= 18'h00000;
            dqo_reg <= flash_host_pkg::RESET_DATA;
            dqe_reg <= 16'h0000;
            word_reg <= 1'b1;
            rst_reg <= 1'b0;
            hv_reg <= 1'b0;
            ready_reg <= 1'b0;
            rsp_reg <= 1'b0;
            rdata_reg <= flash_host_pkg::RESET_DATA;
            busy_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            ce_reg <= ce_next;
            oe_reg <= oe_next;
            we_reg <= we_next;
            addr_reg <= addr_next;
            dqo_reg <= dqo_next;
            dqe_reg <= dqe_next;
            word_reg <= word_next;
            rst_reg <= rst_next;
            hv_reg <= hv_next;
            ready_reg <= ready_next;
            rsp_reg <= rsp_next;
            rdata_reg <= rdata_next;
            busy_reg <= busy_next;
        end
    end

    assign cmd_ready = ready_reg;
    assign rsp_valid = rsp_reg;
    assign rsp_data = rdata_reg;
    assign device_busy = busy_reg;
    assign chip_enable_n = ce_reg;
    assign output_drive_n = oe_reg;
    assign write_strobe_n = we_reg;
    assign addr_out = addr_reg;
    assign dq_out = dqo_reg;
    assign dq_oe = dqe_reg;
    assign word_mode = word_reg;
    assign reset_unprotect_out = rst_reg;
    assign reset_unprotect_oe = 1'b1;
    assign signature_hv = hv_reg;

    a_write_oe_high: assert property (@(posedge clk) disable iff (!resetn)
        !we_reg |-> oe_reg && !ce_reg) else $error("output drive low during write");
    a_read_we_high: assert property (@(posedge clk) disable iff (!resetn)
        !oe_reg |-> we_reg && !ce_reg) else $error("read cycle with strobe low");
    a_reset_pulse_len: assert property (@(posedge clk) disable iff (!resetn)
        $fell(rst_reg) |-> !rst_reg [*8]) else $error("reset pulse too short");
    a_wait_for_ready: assert property (@(posedge clk) disable iff (!resetn)
        (state_reg == flash_host_pkg::BUS_RESET_WAIT && !line_ready) |=> ce_reg && !ready_reg)
        else $error("cycle before ready");
    a_data_float_read: assert property (@(posedge clk) disable iff (!resetn)
        !oe_reg |-> dqe_reg[14:0] == 15'h0000) else $error("data driven during read");
    a_strobe_pulse: assert property (@(posedge clk) disable iff (!resetn)
        $fell(we_reg) |-> !we_reg [*4] ##1 we_reg ##1 !ce_reg) else $error("write strobe width wrong");
    a_byte_select: assert property (@(posedge clk) disable iff (!resetn)
        (!ce_reg && !word_reg) |-> dqe_reg[15] && dqe_reg[14:8] == 7'h00) else $error("byte select not driven");
    a_signature_read: assert property (@(posedge clk) disable iff (!resetn)
        hv_reg |-> we_reg) else $error("high voltage during write");
    a_busy_follows: assert property (@(posedge clk) disable iff (!resetn)
        !line_ready |=> busy_reg) else $error("busy not reported");
endmodule : flash_host

// File: bench/flash_model.sv
// Behavioural flash device answering the host controller's pins
`timescale 1ns/100ps
module flash_model #(
    parameter logic [15:0] MAKER_ID = 16'h00A3, // Arbitrary value
    parameter logic [15:0] PART_ID = 16'h005C, // Arbitrary value
    parameter int ACCESS_NS = 90,
    parameter int PROG_NS = 400,
    parameter int RECOVER_NS = 600
) (
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic [17:0] addr,
    input wire logic [15:0] host_dq,
    input wire logic [15:0] host_oe,
    input wire logic word_mode,
    input wire logic reset_pin_n,
    input wire logic sig_hv,
    input wire logic supply_low,
    output logic [15:0] dq_bus,
    output logic busy_low
);
    logic [15:0] mem [logic [17:0]];
    logic [17:0] lat_addr;
    logic [15:0] word;
    logic [15:0] rd_val;
    logic lat_sel = 0, wr_open = 0, rd_ok = 0, tick = 0, prog_busy = 0, reset_busy = 0;
    realtime fall_t = 0;
    // Released pins toggle so a stale value can never be mistaken for data
    always #10 tick = ~tick;
    always @(negedge ce_n or negedge we_n) begin
        if (!ce_n && !we_n && oe_n && reset_pin_n && !supply_low) begin
            wr_open = 1;
            fall_t = $realtime;
            lat_addr = addr;
            lat_sel = host_dq[15];
        end
    end
    always @(posedge ce_n or posedge we_n) begin
        // A strobe shorter than the glitch filter never reaches the decoder
        if (wr_open && $realtime - fall_t < 5.0) wr_open = 0;
        if (wr_open) begin
            wr_open = 0;
            // Every block is left unprotected here, so each program lands
            word = mem.exists(lat_addr) ? mem[lat_addr] : 16'hFFFF;
            if (word_mode) word = host_dq;
            else if (lat_sel) word[15:8] = host_dq[7:0];
            else word[7:0] = host_dq[7:0];
            mem[lat_addr] = word;
            prog_busy <= 1'b1;
            prog_busy <= #(PROG_NS) 1'b0;
        end
    end
    always @(posedge supply_low) prog_busy = 0;
    always @(reset_pin_n) begin
        if (!reset_pin_n) begin
            reset_busy = 1;
            wr_open = 0;
        end else begin
            reset_busy <= #(RECOVER_NS) 1'b0;
        end
    end
    always @(negedge oe_n) begin
        rd_ok = 0;
        #(ACCESS_NS);
        word = mem.exists(addr) ? mem[addr] : 16'hFFFF;
        if (sig_hv && !addr[1]) word = addr[0] ? PART_ID : MAKER_ID;
        rd_val = word_mode ? word : {8'h00, host_dq[15] ? word[15:8] : word[7:0]};
        rd_ok = !oe_n && !ce_n && we_n && reset_pin_n;
    end
    always @(posedge oe_n or posedge ce_n) rd_ok = 0;
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            if (host_oe[i]) dq_bus[i] = host_dq[i];
            else if (rd_ok && !oe_n && !ce_n && (word_mode || i < 8)) dq_bus[i] = rd_val[i];
            else dq_bus[i] = tick ^ i[0];
        end
    end
    assign busy_low = prog_busy | reset_busy;
endmodule : flash_model

// File: bench/test_flash_host.sv
// Self-checking testbench for the flash host controller
`timescale 1ns/100ps
module test_flash_host;
    localparam logic [15:0] MAKER = 16'h00A3;
    localparam logic [15:0] PART = 16'h005C;
    logic clk = 0, resetn = 0, cmd_valid = 0, cmd_write = 0, cmd_byte_hi = 0, cmd_signature = 0;
    logic byte_mode = 0, reset_request = 0, supply_low = 0;
    logic [17:0] cmd_addr = '0;
    logic [15:0] cmd_wdata = '0;
    logic cmd_ready, rsp_valid, device_busy, chip_enable_n, output_drive_n, write_strobe_n, word_mode;
    logic reset_unprotect_out, signature_hv, busy_low;
    logic [17:0] addr_out;
    logic [15:0] rsp_data, dq_out, dq_oe, dq_bus, rd;
    int fail_count = 0, checked = 0;
    initial forever #10 clk = ~clk;
    flash_host dut_u (.clk(clk), .resetn(resetn), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_byte_hi(cmd_byte_hi), .cmd_wdata(cmd_wdata),
        .cmd_signature(cmd_signature), .byte_mode(byte_mode), .reset_request(reset_request),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data), .device_busy(device_busy),
        .chip_enable_n(chip_enable_n), .output_drive_n(output_drive_n), .write_strobe_n(write_strobe_n),
        .addr_out(addr_out), .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_bus), .word_mode(word_mode),
        .reset_unprotect_out(reset_unprotect_out), .reset_unprotect_oe(), .signature_hv(signature_hv),
        .ready_busy_in(~busy_low));
    flash_model #(.MAKER_ID(MAKER), .PART_ID(PART)) model_u (.ce_n(chip_enable_n), .oe_n(output_drive_n),
        .we_n(write_strobe_n), .addr(addr_out), .host_dq(dq_out), .host_oe(dq_oe), .word_mode(word_mode),
        .reset_pin_n(reset_unprotect_out), .sig_hv(signature_hv), .supply_low(supply_low), .dq_bus(dq_bus),
        .busy_low(busy_low));
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic summarize;
        $display("Comparisons %0d, mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : summarize
    // Pin-level watch; the host must never fight the device on the data pins
    always @(negedge clk) begin
        if (resetn && write_strobe_n === 1'b0) check("oe_high_in_write", output_drive_n, 1);
        if (resetn && output_drive_n === 1'b0)
            check("read_pins", {chip_enable_n, write_strobe_n, dq_oe}, {2'b01, byte_mode, 15'h0000});
    end
    task automatic wait_ready_after_reset;
        int low_cyc = 0;
        bit saw_busy = 0;
        for (int n = 0; n < 200 && cmd_ready !== 1'b1; n++) begin
            @(posedge clk);
            #1;
            if (reset_unprotect_out === 1'b0) low_cyc++;
            if (device_busy === 1'b1) saw_busy = 1;
        end
        check("reset_low_long_enough", low_cyc >= flash_host_pkg::RESET_LOW_CYC, 1);
        check("busy_seen_in_reset", saw_busy, 1);
        check("ready_after_release", {cmd_ready, busy_low}, 2'b10);
        @(negedge clk);
    endtask : wait_ready_after_reset
    task automatic bus_op(input logic wr, input logic [17:0] a, input logic hi, input logic [15:0] wd,
                          input logic sig, output logic [15:0] data);
        bit seen = 0;
        cmd_valid = 1;
        cmd_write = wr;
        cmd_addr = a;
        cmd_byte_hi = hi;
        cmd_wdata = wd;
        cmd_signature = sig;
        for (int n = 0; n < 50; n++) begin
            @(posedge clk);
            if (cmd_ready === 1'b1) break;
        end
        @(negedge clk);
        cmd_valid = 0;
        for (int n = 0; n < 60 && !seen; n++) begin
            @(posedge clk);
            #1;
            seen = wr ? device_busy === 1'b1 : rsp_valid === 1'b1;
        end
        data = rsp_data;
        check(wr ? "program_busy" : "read_answer", seen, wr ? !supply_low : 1'b1);
        for (int n = 0; n < 80 && device_busy !== 1'b0; n++) @(posedge clk);
        @(negedge clk);
    endtask : bus_op
    task automatic t_word_rw;
        bus_op(1, 18'h00000, 0, 16'hA5C3, 0, rd);
        bus_op(1, 18'h3FFFF, 0, 16'h5A3C, 0, rd);
        check("word_mode_pin", word_mode, 1);
        bus_op(0, 18'h00000, 0, 16'h0000, 0, rd);
        check("read_low_addr", rd, 16'hA5C3);
        bus_op(0, 18'h3FFFF, 0, 16'h0000, 0, rd);
        check("read_top_addr", rd, 16'h5A3C);
    endtask : t_word_rw
    task automatic t_byte_rw;
        byte_mode = 1;
        bus_op(1, 18'h00005, 1, 16'h003C, 0, rd);
        bus_op(1, 18'h00005, 0, 16'h0096, 0, rd);
        check("byte_width_pin", word_mode, 0);
        bus_op(0, 18'h00005, 1, 16'h0000, 0, rd);
        check("read_high_byte", rd, 16'h003C);
        bus_op(0, 18'h00005, 0, 16'h0000, 0, rd);
        check("read_low_byte", rd, 16'h0096);
        byte_mode = 0;
        bus_op(0, 18'h00005, 0, 16'h0000, 0, rd);
        check("read_joined_word", rd, 16'h3C96);
    endtask : t_byte_rw
    task automatic t_signature;
        for (int m = 0; m < 2; m++) begin
            byte_mode = m[0];
            bus_op(0, 18'h00100, 0, 16'h0000, 1, rd);
            check("maker_code", rd, m ? {8'h00, MAKER[7:0]} : MAKER);
            bus_op(0, 18'h00101, 0, 16'h0000, 1, rd);
            check("part_code", rd, m ? {8'h00, PART[7:0]} : PART);
        end
        byte_mode = 0;
    endtask : t_signature
    task automatic t_lockout;
        supply_low = 1;
        bus_op(1, 18'h00000, 0, 16'h1111, 0, rd);
        supply_low = 0;
        bus_op(0, 18'h00000, 0, 16'h0000, 0, rd);
        check("lockout_write_ignored", rd, 16'hA5C3);
        fork
            bus_op(1, 18'h00002, 0, 16'h0F0F, 0, rd);
            begin
                wait (device_busy === 1'b1);
                @(negedge clk);
                supply_low = 1;
                repeat (6) @(negedge clk);
                check("abort_frees_line", device_busy, 0);
                supply_low = 0;
            end
        join
    endtask : t_lockout
    task automatic t_hw_reset;
        reset_request = 1;
        for (int n = 0; n < 20 && reset_unprotect_out !== 1'b0; n++) @(negedge clk);
        reset_request = 0;
        wait_ready_after_reset();
        bus_op(0, 18'h00000, 0, 16'h0000, 0, rd);
        check("read_after_reset", rd, 16'hA5C3);
    endtask : t_hw_reset
    initial begin
        #400000;
        fail_count++;
        $display("Error watchdog expected finish seen hang");
        summarize();
    end
    initial begin
        repeat (16) @(posedge clk);
        @(negedge clk);
        resetn = 1;
        wait_ready_after_reset();
        t_word_rw();
        t_byte_rw();
        t_signature();
        t_lockout();
        t_hw_reset();
        summarize();
    end
endmodule : test_flash_host
